// *** common/pbm_defs.vh ***
// register offsets, field positions, reset values and masks for the port b pin mux
`ifndef PBM_DEFS_VH
`define PBM_DEFS_VH

// apb address width and register byte offsets
`define PBM_ADDR_W 8
`define PBM_OFF_LEVELS 8'h00
`define PBM_OFF_LATCH 8'h04
`define PBM_OFF_DIR 8'h08
`define PBM_OFF_ICMAIN 8'h0c
`define PBM_OFF_ICEDGE 8'h10
`define PBM_OFF_ICEXT 8'h14
`define PBM_OFF_ANCFG 8'h18

// interrupt_control_main fields
`define PBM_ICM_CHG_FLAG 0
`define PBM_ICM_MASK 8'hff
`define PBM_ICM_RESET 8'h00

// interrupt_control_edge_pullup fields
`define PBM_ICE_PUD_N 7
`define PBM_ICE_EDGE1 5
`define PBM_ICE_EDGE2 4
`define PBM_ICE_MASK 8'hf5
`define PBM_ICE_RESET 8'hf5

// interrupt_control_external fields
`define PBM_ICX_EXT_IRQ_ONE_FLAG 0
`define PBM_ICX_EXT_IRQ_TWO_FLAG 1
`define PBM_ICX_MASK 8'hdb
`define PBM_ICX_RESET 8'h00

// analog_pin_config fields and power-on values
`define PBM_ANC_MASK 8'h3f
`define PBM_ANC_ALL_ANALOG 8'h00
`define PBM_ANC_PORT_DIGITAL 8'h07
`define PBM_ANC_LIMIT 5'h0e

// output latch and direction power-on values
`define PBM_LATCH_RESET 8'h00
`define PBM_DIR_RESET 8'hff

// analog channel numbers of pins 0 to 4
`define PBM_CH_PIN0 4'hc
`define PBM_CH_PIN1 4'ha
`define PBM_CH_PIN2 4'h8
`define PBM_CH_PIN3 4'h9
`define PBM_CH_PIN4 4'hb

`endif

// *** verification/pbm_pad_model.sv ***
// pad model: external circuitry on the eight port b pins
`timescale 1ns/100ps
`default_nettype none
module pbm_pad_model (
  input wire logic clock, // system clock
  input wire logic [7:0] pin_out, // device drive levels
  input wire logic [7:0] pin_oe, // device drive enables
  input wire logic [7:0] pin_pullup_en, // weak pull-up enables
  input wire logic [7:0] ext_en, // far side drives the pin
  input wire logic [7:0] ext_val, // far side drive levels
  output logic [7:0] pad // resolved pad level
);
  logic [7:0] idle_q = 8'h00;
  // a floating pin shows a level that flips every cycle, never a held value
  always @(posedge clock) begin
    idle_q <= ~idle_q;
  end
  // device drive wins, then far side, then pull-up, else floating
  assign pad = (pin_oe & pin_out) |
    (~pin_oe & ((ext_en & ext_val) | (~ext_en & (pin_pullup_en | idle_q))));
endmodule // pbm_pad_model
`default_nettype wire

// *** verification/pbm_port_b_mux_assertions.sv ***
// concurrent checks on the port b pin mux ports
`timescale 1ns/100ps
`default_nettype none
module pbm_port_b_mux_assertions (
  input wire logic clock, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic [7:0] paddr, // apb address
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic [7:0] pin_out, // pad levels
  input wire logic [7:0] pin_oe, // pad enables
  input wire logic [7:0] pin_pullup_en, // pull-ups
  input wire logic capcomp_alt_pin_cfg, // ccp pin choice
  input wire logic low_voltage_prog_cfg, // entry pin on
  input wire logic in_circuit_debug, // debug on
  input wire logic spi_clk_en, // spi use
  input wire logic spi_clk_out, // spi clock
  input wire logic i2c_en, // i2c use
  input wire logic i2c_clk_out, // i2c clock
  input wire logic xcvr_ext_en, // transceiver on
  input wire logic xcvr_minus_tx, // minus data
  input wire logic capcomp_out_en, // ccp output mode
  input wire logic capcomp_out, // ccp level
  input wire logic serial_prog_data_oe, // debug drive
  input wire logic serial_prog_data_out // debug level
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // setup cycle of a transfer
  sequence apb_setup;
    psel && !penable;
  endsequence
  // spi clock owns bit 1 with a steady level
  sequence spi_held;
    (spi_clk_en && !i2c_en && $stable(spi_clk_out))[*3];
  endsequence
  a_ready_one_cycle: assert property (apb_setup |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  a_unmapped_error: assert property (apb_setup |=> pslverr == ($past(paddr) > 8'h18 ||
    $past(paddr[1:0]) != 2'b00))
    else $error("error flag wrong for address");
  a_pullup_off_out: assert property ((pin_oe & pin_pullup_en) == 8'h00)
    else $error("pull-up on a driven pin");
  a_entry_pin_in: assert property (low_voltage_prog_cfg[*3] |-> !pin_oe[5] && !pin_pullup_en[5])
    else $error("entry pin driven or pulled");
  a_debug_pins: assert property ((in_circuit_debug && $stable(serial_prog_data_oe) &&
    $stable(serial_prog_data_out))[*3] |-> !pin_oe[6] && pin_oe[7] == serial_prog_data_oe &&
    (!pin_oe[7] || pin_out[7] == serial_prog_data_out))
    else $error("debug pins wrong");
  a_spi_clock_out: assert property (spi_held ##0 pin_oe[1] |-> pin_out[1] == spi_clk_out)
    else $error("spi clock not on bit 1");
  a_i2c_clock_out: assert property ((i2c_en && $stable(i2c_clk_out))[*3] ##0 pin_oe[1]
    |-> pin_out[1] == i2c_clk_out)
    else $error("i2c clock not on bit 1");
  a_xcvr_minus_out: assert property ((xcvr_ext_en && $stable(xcvr_minus_tx))[*3] ##0 pin_oe[2]
    |-> pin_out[2] == xcvr_minus_tx)
    else $error("minus data not on bit 2");
  a_ccp_out: assert property ((!capcomp_alt_pin_cfg && capcomp_out_en && !xcvr_ext_en &&
    $stable(capcomp_out))[*3] ##0 pin_oe[3] |-> pin_out[3] == capcomp_out)
    else $error("ccp output not on bit 3");
endmodule // pbm_port_b_mux_assertions
bind pbm_port_b_mux pbm_port_b_mux_assertions u_pbm_port_b_mux_assertions (.clock, .sys_rst,
  .psel, .penable, .paddr, .pready, .pslverr, .pin_out, .pin_oe, .pin_pullup_en,
  .capcomp_alt_pin_cfg, .low_voltage_prog_cfg, .in_circuit_debug, .spi_clk_en, .spi_clk_out,
  .i2c_en, .i2c_clk_out, .xcvr_ext_en, .xcvr_minus_tx, .capcomp_out_en, .capcomp_out,
  .serial_prog_data_oe, .serial_prog_data_out);
`default_nettype wire

// *** verification/pbm_port_b_mux_tb.sv ***
// self-checking bench for the port b pin mux
`timescale 1ns/100ps
`default_nettype none
`include "pbm_defs.vh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module pbm_port_b_mux_tb;
  int err_total = 0, checks = 0;
  logic clock = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slv;
  logic analog_default_cfg = 1'b1, capcomp_alt_pin_cfg = 1'b0;
  logic low_voltage_prog_cfg = 1'b0, in_circuit_debug = 1'b0;
  logic [7:0] paddr = 8'h00, ee = 8'hff, ev = 8'ha5, lt, dr, rr;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] pr = 16'h0000;
  logic [3:0] cfgs [8] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hf};
  logic pready, pslverr, spi_clk_in, i2c_clk_in, i2c_smbus_buf, ext_irq_one, ext_irq_two;
  logic capcomp_in, prog_entry_input, serial_prog_clock, serial_prog_data, pin_change_flag;
  logic analog_channel_8, analog_channel_9, analog_channel_11;
  logic [4:0] analog_pin_en;
  logic [7:0] pin_in, pin_out, pin_oe, pin_pullup_en;
  wire spi_clk_en = pr[0], spi_clk_out = pr[1], i2c_en = pr[2], i2c_clk_out = pr[3];
  wire i2c_smbus_sel = pr[4], xcvr_ext_en = pr[5], xcvr_minus_tx = pr[6], xcvr_plus_tx = pr[7];
  wire capcomp_out_en = pr[8], capcomp_out = pr[9], parallel_port_en = pr[10];
  wire parallel_port_select = pr[11], serial_prog_data_oe = pr[12];
  wire serial_prog_data_out = pr[13];
  pbm_port_b_mux #(.LARGE_PKG(1)) u_pbm_port_b_mux (.clock, .sys_rst, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pin_pullup_en,
    .analog_default_cfg, .capcomp_alt_pin_cfg, .low_voltage_prog_cfg, .in_circuit_debug,
    .spi_clk_en, .spi_clk_out, .i2c_en, .i2c_clk_out, .i2c_smbus_sel, .xcvr_ext_en,
    .xcvr_minus_tx, .xcvr_plus_tx, .capcomp_out_en, .capcomp_out, .parallel_port_en,
    .parallel_port_select, .serial_prog_data_oe, .serial_prog_data_out, .spi_clk_in,
    .i2c_clk_in, .i2c_smbus_buf, .ext_irq_one, .ext_irq_two, .capcomp_in, .prog_entry_input,
    .serial_prog_clock, .serial_prog_data, .analog_channel_8, .analog_channel_9,
    .analog_channel_11, .analog_pin_en, .pin_change_flag);
  pbm_pad_model u_pbm_pad_model (.clock, .pin_out, .pin_oe, .pin_pullup_en, .ext_en(ee),
    .ext_val(ev), .pad(pin_in));
  // clock
  initial begin
    forever #12.5 clock = ~clock;
  end
  // analog pins for a config value: pins 0..4 on channels 12,10,8,9,11
  function automatic logic [4:0] exp_an(input logic [3:0] c);
    return {c <= 4'h3, c <= 4'h5, c <= 4'h6, c <= 4'h4, c <= 4'h2};
  endfunction
  // one transfer; answer taken at the rising edge where pready is high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'hffffff, d};
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clock);
  endtask
  // read and compare a register
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK("read data", {24'h0, e}, rd)
  endtask
  // register values after reset
  task automatic regs_chk(input logic [7:0] anc);
    logic [7:0] rv [6];
    rv = '{8'h00, 8'hff, 8'h00, 8'hf5, 8'h00, anc};
    for (int i = 0; i < 6; i++) begin
      rd_chk(8'(4 * i + 4), rv[i]);
    end
  endtask
  // reset held for eight cycles
  task automatic do_reset(input logic an);
    @(posedge clock);
    analog_default_cfg <= an;
    sys_rst <= 1'b1;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(negedge clock);
  endtask
  // print the counts and the verdict, then stop
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    stop_test();
  end
  // main sequence
  initial begin
    lt = 8'($urandom(53240));
    do_reset(1'b1);
    `CHK("pull-ups", 8'h00, pin_pullup_en)
    `CHK("analog pins", 5'h1f, analog_pin_en)
    regs_chk(8'h00);
    rd_chk(`PBM_OFF_LEVELS, 8'ha0);
    apb(1'b0, 8'h1c, 8'h00);
    `CHK("unmapped error", 1'b1, slv)
    do_reset(1'b0);
    regs_chk(8'h07);
    `CHK("analog pins", 5'h00, analog_pin_en)
    apb(1'b1, `PBM_OFF_ICEDGE, 8'hff);
    rd_chk(`PBM_OFF_ICEDGE, 8'hf5);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `PBM_OFF_ANCFG, {4'hf, cfgs[i]});
      @(negedge clock);
      rr = {3'b000, exp_an(cfgs[i])};
      `CHK("analog pins", exp_an(cfgs[i]), analog_pin_en)
      `CHK("routes", rr[4:2], {analog_channel_11, analog_channel_9, analog_channel_8})
      rd_chk(`PBM_OFF_ANCFG, {4'h3, cfgs[i]});
      rd_chk(`PBM_OFF_LEVELS, ev & ~{3'b000, exp_an(cfgs[i])});
    end
    apb(1'b1, `PBM_OFF_ICEDGE, 8'h75);
    dr = 8'hff;
    for (int i = 0; i < 12; i++) begin
      lt = 8'($urandom);
      ev = 8'($urandom);
      ee = (i == 0) ? 8'h00 : 8'($urandom);
      rr = dr;
      dr = (i == 1) ? 8'h00 : 8'($urandom);
      apb(1'b1, `PBM_OFF_LATCH, lt);
      apb(1'b1, `PBM_OFF_DIR, dr);
      `CHK("drive enables", ~rr, pin_oe)
      @(negedge clock);
      `CHK("drive enables", ~dr, pin_oe)
      `CHK("drive levels", lt & ~dr, pin_out & ~dr)
      `CHK("pull-ups", dr, pin_pullup_en)
      repeat (3) @(negedge clock);
      rd_chk(`PBM_OFF_LEVELS, (dr & ((ev & ee) | ~ee)) | (lt & ~dr));
    end
    ee = 8'hff;
    ev = 8'h00;
    apb(1'b1, `PBM_OFF_LATCH, 8'h00);
    apb(1'b1, `PBM_OFF_DIR, 8'hff);
    repeat (4) @(negedge clock);
    apb(1'b0, `PBM_OFF_LEVELS, 8'h00);
    apb(1'b1, `PBM_OFF_ICMAIN, 8'h00);
    ev = 8'h0f;
    repeat (6) @(negedge clock);
    `CHK("change flag", 1'b0, pin_change_flag)
    ev = 8'h4f;
    repeat (6) @(negedge clock);
    `CHK("change flag", 1'b1, pin_change_flag)
    apb(1'b1, `PBM_OFF_ICMAIN, 8'h00);
    repeat (2) @(negedge clock);
    `CHK("change flag", 1'b1, pin_change_flag)
    apb(1'b0, `PBM_OFF_LEVELS, 8'h00);
    apb(1'b1, `PBM_OFF_ICMAIN, 8'h00);
    repeat (2) @(negedge clock);
    `CHK("change flag", 1'b0, pin_change_flag)
    apb(1'b1, `PBM_OFF_DIR, 8'h7f);
    apb(1'b1, `PBM_OFF_LATCH, 8'h80);
    repeat (6) @(negedge clock);
    `CHK("change flag", 1'b0, pin_change_flag)
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      pr <= k[0] ? {11'h000, k[1], 4'h4} : 16'h0001;
      low_voltage_prog_cfg <= 1'b1;
      in_circuit_debug <= 1'b1;
      ev <= 8'($urandom);
      if (k == 0) apb(1'b1, `PBM_OFF_DIR, 8'hff);
      repeat (6) @(negedge clock);
      `CHK("clock input", ev[1], k[0] ? i2c_clk_in : spi_clk_in)
      if (k[0]) `CHK("input buffer", k[1], i2c_smbus_buf)
      `CHK("interrupt one", ev[1], ext_irq_one)
      `CHK("interrupt two", ev[2], ext_irq_two)
      `CHK("capture input", ev[3], capcomp_in)
      `CHK("entry input", ev[5], prog_entry_input)
      `CHK("prog clock", ev[6], serial_prog_clock)
      `CHK("prog data", ev[7], serial_prog_data)
    end
    apb(1'b1, `PBM_OFF_DIR, 8'h00);
    @(negedge clock);
    `CHK("taken pins", 8'h00, pin_oe & 8'he0)
    for (int i = 0; i < 40; i++) begin
      @(posedge clock);
      pr <= 16'($urandom);
      in_circuit_debug <= i[3];
      low_voltage_prog_cfg <= 1'b0;
      repeat (4) @(negedge clock);
      if (pr[10]) `CHK("select out", pr[11], pin_out[4])
      if (pr[5]) `CHK("minus data", pr[6], pin_out[2])
      if (pr[5]) `CHK("plus data", pr[7], pin_out[3])
    end
    stop_test();
  end
endmodule // pbm_port_b_mux_tb
`default_nettype wire

// *** verilog/pbm_change_detect.v ***
// interrupt-on-change mismatch detector for pins 4 to 7
`timescale 1ns/100ps
`default_nettype none
module pbm_change_detect (
  input wire clock, // system clock
  input wire sys_rst, // synchronous reset, active high
  input wire [3:0] pins, // synchronised levels of pins 4 to 7
  input wire [3:0] watch, // pins that take part in the comparison
  input wire port_access, // pulse: read or write of the pin levels register
  output reg mismatch_q // level: some watched pin differs from the snapshot
);
  reg [3:0] old_q;

  // snapshot taken at every port access ends the mismatch
  always @(posedge clock) begin
    if (sys_rst) begin
      old_q <= 4'h0;
      mismatch_q <= 1'b0;
    end else begin
      if (port_access) begin
        old_q <= pins;
      end
      mismatch_q <= ~port_access & (|((pins ^ old_q) & watch));
    end
  end
endmodule // pbm_change_detect
`default_nettype wire

// *** verilog/pbm_port_b_mux.v ***
// port b pin function multiplexer with apb register slave
`timescale 1ns/100ps
`include "pbm_defs.vh"
`default_nettype none
// Summary of operation
// - direction 0 drives pin from output latch
// - direction 1 reads pin, pull-up per control
// - bit 1 spi clock overrides latch, input
// - bit 1 i2c clock priority, buffer follows setting
// - bits 1,2 feed external interrupts one, two
// - bits 2,3 carry external transceiver transmit data
// - alt-pin config 0: bit 3 is ccp two
// - bits 4-7 inputs not taken by programming are change inputs
// - bit 4 parallel select on large package only
// - low-voltage config makes bit 5 entry input
// - debug makes bits 6,7 programming clock, data
// - power-on analog or digital from config bit
// - programming functions on bits 5-7 set pin direction; others need direction 0
// - unimplemented register bits read as zero
// - change compare against last-access snapshot, inputs only
// - mismatch keeps flag set; access ends mismatch
// - pull-ups off for outputs and after reset
// - analog pins read zero through port register
module pbm_port_b_mux #(
  parameter LARGE_PKG = 1 // 1 when the parallel port select pin exists
) (
  input wire clock, // system clock, 40 mhz
  input wire sys_rst, // synchronous reset, active high
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb write
  input wire [`PBM_ADDR_W-1:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error on unmapped address
  input wire [7:0] pin_in, // pad input levels
  output reg [7:0] pin_out, // pad output levels
  output reg [7:0] pin_oe, // pad output enables, high drives
  output reg [7:0] pin_pullup_en, // weak pull-up enables
  input wire analog_default_cfg, // power-on config: port pins analog
  input wire capcomp_alt_pin_cfg, // 0 puts ccp two on bit 3
  input wire low_voltage_prog_cfg, // bit 5 is programming entry
  input wire in_circuit_debug, // serial programming or debug active
  input wire spi_clk_en, // serial module in spi clock use
  input wire spi_clk_out, // spi clock from serial module
  input wire i2c_en, // serial module in i2c use
  input wire i2c_clk_out, // i2c clock from serial module
  input wire i2c_smbus_sel, // serial module selects smbus levels
  input wire xcvr_ext_en, // external usb transceiver in use
  input wire xcvr_minus_tx, // minus line transmit data
  input wire xcvr_plus_tx, // plus line transmit data
  input wire capcomp_out_en, // ccp two in compare or pwm mode
  input wire capcomp_out, // ccp two compare or pwm level
  input wire parallel_port_en, // parallel port owns its select pin
  input wire parallel_port_select, // parallel port select level
  input wire serial_prog_data_oe, // debug logic drives data line
  input wire serial_prog_data_out, // debug data output level
  output reg spi_clk_in, // spi clock into serial module
  output reg i2c_clk_in, // i2c clock into serial module
  output reg i2c_smbus_buf, // bit 1 input buffer uses smbus levels
  output reg ext_irq_one, // external interrupt one input level
  output reg ext_irq_two, // external interrupt two input level
  output reg capcomp_in, // ccp two capture input
  output reg prog_entry_input, // programming mode entry level
  output reg serial_prog_clock, // programming clock input
  output reg serial_prog_data, // programming data input
  output reg analog_channel_8, // bit 2 routed to channel 8
  output reg analog_channel_9, // bit 3 routed to channel 9
  output reg analog_channel_11, // bit 4 routed to channel 11
  output reg [4:0] analog_pin_en, // analog selection of pins 0 to 4
  output reg pin_change_flag // sticky change flag copy
);
  // channel n is analog while the config field is no more than 14 - n
  function an_on;
    input [3:0] pcfg;
    input [3:0] ch;
    begin
      an_on = ({1'b0, pcfg} + {1'b0, ch}) <= `PBM_ANC_LIMIT;
    end
  endfunction

  reg [7:0] output_latch_bits_q;
  reg [7:0] pin_direction_bits_q;
  reg [7:0] icmain_q;
  reg [7:0] icedge_q;
  reg [7:0] icext_q;
  reg [7:0] ancfg_q;
  reg [7:0] prev_lvl_q;
  reg [2:0] settle_q;
  reg [31:0] rd_d;
  reg hit_d;
  reg [7:0] out_d;
  reg [7:0] oe_d;
  wire [7:0] pin_sync;
  wire [7:0] pin_level_bits;
  wire [7:0] an_mask;
  wire [7:0] dig_in;
  wire mismatch;
  wire setup;
  wire wr_go;
  wire rd_go;
  wire pullup_disable_n;
  wire edge1;
  wire edge2;
  wire rise1;
  wire rise2;
  wire fall1;
  wire fall2;
  wire [3:0] watch;
  wire armed;
  wire [7:0] icx_wr;

  // pad levels enter the clock domain
  pbm_sync2 u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // analog selection per pin; bits 5 to 7 have no analog channel
  assign an_mask = {3'b000,
    an_on(ancfg_q[3:0], `PBM_CH_PIN4),
    an_on(ancfg_q[3:0], `PBM_CH_PIN3),
    an_on(ancfg_q[3:0], `PBM_CH_PIN2),
    an_on(ancfg_q[3:0], `PBM_CH_PIN1),
    an_on(ancfg_q[3:0], `PBM_CH_PIN0)};

  // digital input buffer off on analog pins
  assign dig_in = pin_sync & ~an_mask;
  assign pin_level_bits = dig_in;
  assign pullup_disable_n = icedge_q[`PBM_ICE_PUD_N];
  assign edge1 = icedge_q[`PBM_ICE_EDGE1];
  assign edge2 = icedge_q[`PBM_ICE_EDGE2];

  // apb phases; the access phase always completes in its first cycle
  assign setup = psel & ~penable;
  assign wr_go = psel & penable & pready & pwrite;
  assign rd_go = psel & penable & pready & ~pwrite;

  // change inputs: input-configured pins not taken by programming
  assign watch = pin_direction_bits_q[7:4] &
    {in_circuit_debug, in_circuit_debug, low_voltage_prog_cfg, 1'b0} ^
    pin_direction_bits_q[7:4] & ~{in_circuit_debug, in_circuit_debug,
    low_voltage_prog_cfg, 1'b0} ^ pin_direction_bits_q[7:4] &
    {in_circuit_debug, in_circuit_debug, low_voltage_prog_cfg, 1'b0};

  // snapshot follows the pins until they settle after reset, so no false change
  pbm_change_detect u_chg (
    .clock(clock),
    .sys_rst(sys_rst),
    .pins(dig_in[7:4]),
    .watch(watch),
    .port_access(~armed | ((wr_go | rd_go) & (paddr == `PBM_OFF_LEVELS))),
    .mismatch_q(mismatch)
  );

  // edges count only once synchroniser and history hold real pin levels
  assign armed = settle_q[2];
  assign rise1 = armed & dig_in[1] & ~prev_lvl_q[1];
  assign fall1 = armed & ~dig_in[1] & prev_lvl_q[1];
  assign rise2 = armed & dig_in[2] & ~prev_lvl_q[2];
  assign fall2 = armed & ~dig_in[2] & prev_lvl_q[2];
  assign icx_wr = pwdata[7:0] & `PBM_ICX_MASK;

  // register read mux and address decode
  always @* begin
    rd_d = 32'h0000_0000;
    hit_d = 1'b1;
    case (paddr)
      `PBM_OFF_LEVELS: rd_d[7:0] = pin_level_bits;
      `PBM_OFF_LATCH: rd_d[7:0] = output_latch_bits_q;
      `PBM_OFF_DIR: rd_d[7:0] = pin_direction_bits_q;
      `PBM_OFF_ICMAIN: rd_d[7:0] = icmain_q & `PBM_ICM_MASK;
      `PBM_OFF_ICEDGE: rd_d[7:0] = icedge_q & `PBM_ICE_MASK;
      `PBM_OFF_ICEXT: rd_d[7:0] = icext_q & `PBM_ICX_MASK;
      `PBM_OFF_ANCFG: rd_d[7:0] = ancfg_q & `PBM_ANC_MASK;
      default: hit_d = 1'b0;
    endcase
  end

  // apb answer: ready, error and data in the access phase
  always @(posedge clock) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup & ~hit_d;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_d;
      end
    end
  end

  // software registers; writes to the pin levels register land in the latch
  always @(posedge clock) begin
    if (sys_rst) begin
      output_latch_bits_q <= `PBM_LATCH_RESET;
      pin_direction_bits_q <= `PBM_DIR_RESET;
      icedge_q <= `PBM_ICE_RESET;
      ancfg_q <= analog_default_cfg ? `PBM_ANC_ALL_ANALOG :
        `PBM_ANC_PORT_DIGITAL;
      prev_lvl_q <= 8'h00;
      settle_q <= 3'b000;
    end else begin
      prev_lvl_q <= dig_in;
      settle_q <= {settle_q[1:0], 1'b1};
      if (wr_go) begin
        case (paddr)
          `PBM_OFF_LEVELS: output_latch_bits_q <= pwdata[7:0];
          `PBM_OFF_LATCH: output_latch_bits_q <= pwdata[7:0];
          `PBM_OFF_DIR: pin_direction_bits_q <= pwdata[7:0];
          `PBM_OFF_ICEDGE: icedge_q <= pwdata[7:0] & `PBM_ICE_MASK;
          `PBM_OFF_ANCFG: ancfg_q <= pwdata[7:0] & `PBM_ANC_MASK;
          default: ancfg_q <= ancfg_q;
        endcase
      end
    end
  end

  // sticky flags: hardware set wins over a software clear
  always @(posedge clock) begin
    if (sys_rst) begin
      icmain_q <= `PBM_ICM_RESET;
      icext_q <= `PBM_ICX_RESET;
    end else begin
      if (wr_go && paddr == `PBM_OFF_ICMAIN) begin
        icmain_q[7:1] <= pwdata[7:1];
        icmain_q[`PBM_ICM_CHG_FLAG] <= pwdata[0] | mismatch;
      end else begin
        icmain_q[`PBM_ICM_CHG_FLAG] <= icmain_q[`PBM_ICM_CHG_FLAG] | mismatch;
      end
      if (wr_go && paddr == `PBM_OFF_ICEXT) begin
        icext_q[7:2] <= icx_wr[7:2];
        icext_q[`PBM_ICX_EXT_IRQ_ONE_FLAG] <= pwdata[0] |
          (pin_direction_bits_q[1] & (edge1 ? rise1 : fall1));
        icext_q[`PBM_ICX_EXT_IRQ_TWO_FLAG] <= pwdata[1] |
          (pin_direction_bits_q[2] & (edge2 ? rise2 : fall2));
      end else begin
        icext_q[`PBM_ICX_EXT_IRQ_ONE_FLAG] <= icext_q[`PBM_ICX_EXT_IRQ_ONE_FLAG] |
          (pin_direction_bits_q[1] & (edge1 ? rise1 : fall1));
        icext_q[`PBM_ICX_EXT_IRQ_TWO_FLAG] <= icext_q[`PBM_ICX_EXT_IRQ_TWO_FLAG] |
          (pin_direction_bits_q[2] & (edge2 ? rise2 : fall2));
      end
    end
  end

  // per-pin drive selection; peripherals take priority over the latch
  always @* begin
    out_d = output_latch_bits_q;
    oe_d = ~pin_direction_bits_q;
    if (!pin_direction_bits_q[1]) begin
      if (i2c_en) begin
        out_d[1] = i2c_clk_out;
      end else if (spi_clk_en) begin
        out_d[1] = spi_clk_out;
      end
    end
    if (xcvr_ext_en && !pin_direction_bits_q[2]) begin
      out_d[2] = xcvr_minus_tx;
    end
    if (!pin_direction_bits_q[3]) begin
      if (xcvr_ext_en) begin
        out_d[3] = xcvr_plus_tx;
      end else if (!capcomp_alt_pin_cfg && capcomp_out_en) begin
        out_d[3] = capcomp_out;
      end
    end
    if (LARGE_PKG != 0 && parallel_port_en && !pin_direction_bits_q[4]) begin
      out_d[4] = parallel_port_select;
    end
    if (low_voltage_prog_cfg) begin
      oe_d[5] = 1'b0;
    end
    if (in_circuit_debug) begin
      oe_d[6] = 1'b0;
      oe_d[7] = serial_prog_data_oe;
      out_d[7] = serial_prog_data_out;
    end
  end

  // pad drive, one edge after the register write completes
  always @(posedge clock) begin
    if (sys_rst) begin
      pin_out <= 8'h00;
      pin_oe <= 8'h00;
      pin_pullup_en <= 8'h00;
    end else begin
      pin_out <= out_d;
      pin_oe <= oe_d;
      pin_pullup_en <= {8{~pullup_disable_n}} & ~oe_d & ~an_mask &
        ~{in_circuit_debug, in_circuit_debug, low_voltage_prog_cfg, 5'b00000};
    end
  end

  // inputs handed to the peripherals, analog routing and flag copy
  always @(posedge clock) begin
    if (sys_rst) begin
      spi_clk_in <= 1'b0;
      i2c_clk_in <= 1'b0;
      i2c_smbus_buf <= 1'b0;
      ext_irq_one <= 1'b0;
      ext_irq_two <= 1'b0;
      capcomp_in <= 1'b0;
      prog_entry_input <= 1'b0;
      serial_prog_clock <= 1'b0;
      serial_prog_data <= 1'b0;
      analog_channel_8 <= 1'b0;
      analog_channel_9 <= 1'b0;
      analog_channel_11 <= 1'b0;
      analog_pin_en <= 5'h00;
      pin_change_flag <= 1'b0;
    end else begin
      spi_clk_in <= spi_clk_en & pin_direction_bits_q[1] & dig_in[1];
      i2c_clk_in <= i2c_en & dig_in[1];
      i2c_smbus_buf <= i2c_en & i2c_smbus_sel;
      ext_irq_one <= pin_direction_bits_q[1] & dig_in[1];
      ext_irq_two <= pin_direction_bits_q[2] & dig_in[2];
      capcomp_in <= ~capcomp_alt_pin_cfg & pin_direction_bits_q[3] & dig_in[3];
      prog_entry_input <= low_voltage_prog_cfg & pin_sync[5];
      serial_prog_clock <= in_circuit_debug & pin_sync[6];
      serial_prog_data <= in_circuit_debug & pin_sync[7];
      analog_channel_8 <= pin_direction_bits_q[2] & an_mask[2];
      analog_channel_9 <= pin_direction_bits_q[3] & an_mask[3];
      analog_channel_11 <= pin_direction_bits_q[4] & an_mask[4];
      analog_pin_en <= an_mask[4:0];
      pin_change_flag <= icmain_q[`PBM_ICM_CHG_FLAG];
    end
  end
endmodule // pbm_port_b_mux
`default_nettype wire

// *** verilog/pbm_sync2.v ***
// two flip-flop synchroniser for the eight port pins
`timescale 1ns/100ps
`default_nettype none
module pbm_sync2 (
  input wire clock, // system clock
  input wire sys_rst, // synchronous reset, active high
  input wire [7:0] async_in, // raw pin levels
  output reg [7:0] sync_out // pin levels in the clock domain
);
  reg [7:0] meta_q;

  // first stage feeds only the second stage
  always @(posedge clock) begin
    if (sys_rst) begin
      meta_q <= 8'h00;
      sync_out <= 8'h00;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // pbm_sync2
`default_nettype wire
